// >>> hdl/pfcts_defs.svh
`ifndef PFCTS_DEFS_SVH
`define PFCTS_DEFS_SVH

`define PFCTS_CLK_HZ 200000000
`define PFCTS_FSW_HZ 65000
`define PFCTS_PERIOD (`PFCTS_CLK_HZ / `PFCTS_FSW_HZ)
`define PFCTS_TICK_HZ 6500
`define PFCTS_TICK_CYC (`PFCTS_CLK_HZ / `PFCTS_TICK_HZ)
`define PFCTS_RELAY_MS 20
`define PFCTS_RELAY_CYC (`PFCTS_RELAY_MS * (`PFCTS_CLK_HZ / 1000))
`define PFCTS_RESTART_MS 500
`define PFCTS_RESTART_CYC (`PFCTS_RESTART_MS * (`PFCTS_CLK_HZ / 1000))
`define PFCTS_BULK_UV_V 333
`define PFCTS_COEF_SPLIT_A 15
`define PFCTS_CUR_LSB_PER_A 10
`define PFCTS_DUTY_RST 12'h000
`define PFCTS_CMP_TRAP 0
`define PFCTS_CMP_ZERO 1

`endif

// >>> hdl/pfcts_pkg.sv
package pfcts_pkg;
    typedef logic [11:0] pfcts_cnt_t;
    typedef logic [9:0] pfcts_volt_t;
    typedef logic [9:0] pfcts_amp_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RELAY,
        ST_RUN,
        ST_HOLD,
        ST_RESTART
    } pfcts_state_e;
endpackage

// >>> hdl/pfcts_cap_if.sv
`timescale 1ns/100ps
interface pfcts_cap_if;
    logic start;
    logic zc_fall;
    pfcts_pkg::pfcts_cnt_t cond_time;
    logic cap_valid;
    modport ctrl (output start, output zc_fall, input cond_time,
        input cap_valid);
    modport cap (input start, input zc_fall, output cond_time,
        output cap_valid);
endinterface

// >>> hdl/pfcts_capture.sv
`timescale 1ns/100ps
module pfcts_capture (
    input wire logic ref_clk,
    input wire logic resetn,
    pfcts_cap_if.cap cap
);
    import pfcts_pkg::*;

    pfcts_cnt_t cnt;
    logic armed;

    // The counter saturates so a missing zero crossing cannot wrap it.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cnt <= '0;
        end else if (cap.start) begin
            cnt <= '0;
        end else if (cnt != 12'hFFF) begin
            cnt <= cnt + 12'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            armed <= 1'b0;
            cap.cond_time <= '0;
            cap.cap_valid <= 1'b0;
        end else begin
            cap.cap_valid <= 1'b0;
            if (cap.start) begin
                armed <= 1'b1;
            end else if (armed && cap.zc_fall) begin
                armed <= 1'b0;
                cap.cond_time <= cnt;
                cap.cap_valid <= 1'b1;
            end
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    AST_CAP_RESTART: assert property (cap.start |=> cnt == 12'h000)
        else $error("capture counter not restarted");
    AST_CAP_VALUE: assert property (
        (armed && !cap.start && cap.zc_fall) |=>
            cap.cap_valid && cap.cond_time == $past(cnt))
        else $error("conduction time not captured");
endmodule

// >>> hdl/pfcts_timing.sv
// Notes on behaviour
// - Main PWM period at 65 kHz.
// - First compare holds duty on-time.
// - Half-duty compare triggers current sampling.
// - Current conversion done raises control event.
// - Replica timer triggers voltage sampling mid off-time.
// - Separate 6.5 kHz periodic tick.
// - Peak comparator forces PWM low.
// - Capture slice measures conduction time.
// - Zero-current comparator ends conduction measurement.
// - Extra timers make comparator reference PWMs.
// - Two triggers serve current and voltage channels.
// - Relay closes before PWM is enabled.
// - Relay opens only on bulk undervoltage.
// - Capture restarts at period, captures falling edge.
// - Overshoot holds PWM off until target.
// - Below 333 V shut down, wait, then idle until a new start request.
`timescale 1ns/100ps
`include "pfcts_defs.svh"
module pfcts_timing #(
    parameter int unsigned TICK_CYCLES = `PFCTS_TICK_CYC,
    parameter int unsigned RELAY_CYCLES = `PFCTS_RELAY_CYC,
    parameter int unsigned RESTART_CYCLES = `PFCTS_RESTART_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic start_req,
    input wire pfcts_pkg::pfcts_cnt_t duty_compare_value,
    input wire logic adc_cur_done,
    input wire pfcts_pkg::pfcts_amp_t cur_sample,
    input wire pfcts_pkg::pfcts_volt_t bulk_volts,
    input wire pfcts_pkg::pfcts_volt_t ovp_level,
    input wire pfcts_pkg::pfcts_volt_t target_level,
    input wire logic [15:0] ref_levels,
    input wire logic peak_current_limit,
    input wire logic zero_current,
    output logic pwm_out,
    output logic adc_cur_trig,
    output logic adc_volt_trig,
    output logic cur_ctrl_event,
    output logic slow_tick,
    output logic [1:0] ref_pwm,
    output logic relay_close,
    output logic soft_start,
    output logic coef_high,
    output pfcts_pkg::pfcts_cnt_t cond_time,
    output logic cond_valid
);
    import pfcts_pkg::*;

    localparam pfcts_cnt_t LAST = pfcts_cnt_t'(`PFCTS_PERIOD - 1);
    localparam pfcts_cnt_t PER = pfcts_cnt_t'(`PFCTS_PERIOD);
    localparam pfcts_volt_t BULK_UV = pfcts_volt_t'(`PFCTS_BULK_UV_V);
    localparam pfcts_amp_t CUR_SPLIT =
        pfcts_amp_t'(`PFCTS_COEF_SPLIT_A * `PFCTS_CUR_LSB_PER_A);

    if (TICK_CYCLES < 2 || RELAY_CYCLES < 1 || RESTART_CYCLES < 1)
    begin : g_chk
        $error("pfcts_timing: cycle counts too small");
    end

    // Comparator pins: three flops, a level change counts once the
    // second and third stages agree.
    logic [2:0] sync_sr [2];
    logic [1:0] cmp_lvl;
    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                sync_sr[i] <= 3'h0;
                cmp_lvl[i] <= 1'b0;
            end else begin
                sync_sr[i] <= {sync_sr[i][1:0],
                    (i == 0) ? peak_current_limit : zero_current};
                if (sync_sr[i][1] == sync_sr[i][2]) begin
                    cmp_lvl[i] <= sync_sr[i][2];
                end
            end
        end
    end

    logic trap;
    logic zero_prev;
    assign trap = cmp_lvl[`PFCTS_CMP_TRAP];

    pfcts_cnt_t cnt, rep_cnt, duty_act, half_act, mid_off;
    pfcts_cnt_t duty_sat;
    pfcts_state_e state;
    logic run_pwm;
    logic [31:0] wait_cnt, tick_cnt;
    logic [7:0] ref_cnt;

    always_ff @(posedge ref_clk) begin
        if (!resetn || cnt == LAST) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 12'h001;
        end
    end

    // The replica restarts on every main wrap, so the two never drift.
    always_ff @(posedge ref_clk) begin
        if (!resetn || cnt == LAST) begin
            rep_cnt <= '0;
        end else begin
            rep_cnt <= rep_cnt + 12'h001;
        end
    end

    // A duty change mid-period would give a runt pulse, so it waits.
    assign duty_sat = (duty_compare_value > LAST) ? LAST
        : duty_compare_value;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            duty_act <= `PFCTS_DUTY_RST;
            half_act <= `PFCTS_DUTY_RST;
            mid_off <= LAST;
        end else if (cnt == LAST) begin
            duty_act <= duty_sat;
            half_act <= duty_sat >> 1;
            mid_off <= duty_sat + ((PER - duty_sat) >> 1);
        end
    end

    assign run_pwm = (state == ST_RUN) && bulk_volts >= BULK_UV;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= run_pwm && !trap && cnt < duty_act;
        end
    end

    // Two separate triggers: current at mid on-time, bulk mid off-time.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            adc_cur_trig <= 1'b0;
            adc_volt_trig <= 1'b0;
        end else begin
            adc_cur_trig <= run_pwm && half_act != 12'h000
                && cnt == half_act;
            adc_volt_trig <= run_pwm && rep_cnt == mid_off;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cur_ctrl_event <= 1'b0;
            coef_high <= 1'b0;
        end else begin
            cur_ctrl_event <= adc_cur_done;
            if (adc_cur_done) begin
                coef_high <= cur_sample >= CUR_SPLIT;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            tick_cnt <= '0;
            slow_tick <= 1'b0;
        end else if (tick_cnt == TICK_CYCLES - 1) begin
            tick_cnt <= '0;
            slow_tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
            slow_tick <= 1'b0;
        end
    end

    // The reference PWMs feed external RC filters, hence the fast 8-bit
    // counter: ripple is traded for simplicity.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ref_cnt <= '0;
        end else begin
            ref_cnt <= ref_cnt + 8'h01;
        end
    end
    for (genvar i = 0; i < 2; i++) begin : g_ref
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                ref_pwm[i] <= 1'b0;
            end else begin
                ref_pwm[i] <= ref_cnt < ref_levels[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state <= ST_IDLE;
            relay_close <= 1'b0;
            soft_start <= 1'b0;
            wait_cnt <= '0;
        end else begin
            soft_start <= 1'b0;
            wait_cnt <= wait_cnt + 32'h00000001;
            unique case (state)
                ST_IDLE: begin
                    wait_cnt <= '0;
                    if (start_req) begin
                        state <= ST_RELAY;
                        relay_close <= 1'b1;
                    end
                end
                ST_RELAY: begin
                    if (wait_cnt >= RELAY_CYCLES - 1) begin
                        state <= ST_RUN;
                        soft_start <= 1'b1;
                    end
                end
                ST_RUN, ST_HOLD: begin
                    wait_cnt <= '0;
                    if (bulk_volts < BULK_UV) begin
                        state <= ST_RESTART;
                        relay_close <= 1'b0;
                    end else if (state == ST_RUN
                        && bulk_volts > ovp_level) begin
                        state <= ST_HOLD;
                    end else if (state == ST_HOLD
                        && bulk_volts <= target_level) begin
                        state <= ST_RUN;
                    end
                end
                ST_RESTART: begin
                    if (wait_cnt >= RESTART_CYCLES - 1) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    pfcts_cap_if cap_bus ();
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            zero_prev <= 1'b0;
        end else begin
            zero_prev <= cmp_lvl[`PFCTS_CMP_ZERO];
        end
    end
    assign cap_bus.start = (cnt == 12'h000);
    assign cap_bus.zc_fall = zero_prev
        && !cmp_lvl[`PFCTS_CMP_ZERO];
    assign cond_time = cap_bus.cond_time;
    assign cond_valid = cap_bus.cap_valid;

    pfcts_capture u_cap (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .cap(cap_bus.cap)
    );

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_wrap;
        cnt == LAST;
    endsequence
    sequence s_restart;
        cnt == 12'h000 && rep_cnt == 12'h000;
    endsequence

    AST_PERIOD: assert property (s_wrap |=> s_restart)
        else $error("main or replica timer did not wrap together");
    AST_SHADOW: assert property (cnt != LAST |=> $stable(duty_act))
        else $error("duty compare changed mid period");
    AST_PWM_ON: assert property (
        (run_pwm && !trap && cnt < duty_act) |=> pwm_out)
        else $error("pwm low inside on-time");
    AST_CUR_TRIG: assert property (
        adc_cur_trig |-> $past(cnt) == $past(half_act)
            && $past(half_act) == ($past(duty_act) >> 1))
        else $error("current trigger not at half duty");
    AST_ISR: assert property (adc_cur_done |=> cur_ctrl_event)
        else $error("control event missing after conversion");
    AST_VOLT_TRIG: assert property (
        adc_volt_trig |-> $past(rep_cnt) == $past(mid_off))
        else $error("voltage trigger not at mid off-time");
    AST_TICK: assert property (slow_tick |=> !slow_tick)
        else $error("slow tick longer than one cycle");
    AST_TRAP: assert property (trap |=> !pwm_out)
        else $error("pwm high during peak current trap");
    AST_RELAY_FIRST: assert property (pwm_out |-> relay_close)
        else $error("pwm active with relay open");
    AST_RELAY_OPEN: assert property (
        $fell(relay_close) |-> $past(bulk_volts) < BULK_UV)
        else $error("relay opened without undervoltage");
    AST_OVP: assert property (
        (state == ST_HOLD) |=> !pwm_out)
        else $error("pwm active during overshoot hold");
endmodule

// >>> test/pfcts_stage_model.sv
`timescale 1ns/100ps
module pfcts_stage_model (
    input wire logic ref_clk,
    input wire logic pwm_out,
    input wire logic adc_cur_trig,
    input wire logic over_cur,
    input wire logic [3:0] tail,
    output logic adc_cur_done,
    output logic peak_current_limit,
    output logic zero_current
);
    logic [2:0] conv = 3'h0;
    logic [3:0] left = 4'h0;
    // The converter answers a fixed few cycles after its trigger.
    always @(negedge ref_clk) begin
        adc_cur_done <= (conv == 3'h1);
        conv <= adc_cur_trig ? 3'h4 : conv - 3'(conv != 3'h0);
    end
    // Current decays for tail cycles after the switch opens, as in
    // discontinuous conduction.
    always @(negedge ref_clk) begin
        left <= pwm_out ? tail : left - 4'(left != 4'h0);
    end
    assign zero_current = pwm_out | (left != 4'h0);
    assign peak_current_limit = over_cur;
endmodule

// >>> test/testbench.sv
`timescale 1ns/100ps
module testbench;
    import pfcts_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic start_req = 1'b0;
    pfcts_cnt_t duty = 12'h000;
    pfcts_amp_t cur_sample = 10'h000;
    pfcts_volt_t bulk = 10'h190;
    pfcts_volt_t ovp = 10'h1C2;
    pfcts_volt_t target = 10'h190;
    logic [15:0] ref_levels = 16'h0000;
    logic over_cur = 1'b0;
    logic adc_cur_done, peak, zero_cur, pwm_out, ctrig, vtrig, cev;
    logic slow_tick, relay_close, soft_start, coef_high, cond_valid;
    logic prev_done = 1'b0;
    logic [1:0] ref_pwm;
    pfcts_cnt_t cond_time;
    logic [31:0] rnd = 32'd98;
    logic exp_q[$];
    int failures = 0;
    int checks_done = 0;

    always #2.5 ref_clk = ~ref_clk;

    pfcts_timing #(.TICK_CYCLES(20), .RELAY_CYCLES(10),
        .RESTART_CYCLES(10)) dut (.ref_clk(ref_clk), .resetn(resetn),
        .start_req(start_req), .duty_compare_value(duty),
        .adc_cur_done(adc_cur_done), .cur_sample(cur_sample),
        .bulk_volts(bulk), .ovp_level(ovp), .target_level(target),
        .ref_levels(ref_levels), .peak_current_limit(peak),
        .zero_current(zero_cur), .pwm_out(pwm_out), .adc_cur_trig(ctrig),
        .adc_volt_trig(vtrig), .cur_ctrl_event(cev), .slow_tick(slow_tick),
        .ref_pwm(ref_pwm), .relay_close(relay_close),
        .soft_start(soft_start), .coef_high(coef_high),
        .cond_time(cond_time), .cond_valid(cond_valid));

    pfcts_stage_model u_stage (.ref_clk(ref_clk), .pwm_out(pwm_out),
        .adc_cur_trig(ctrig), .over_cur(over_cur), .tail(4'h8),
        .adc_cur_done(adc_cur_done), .peak_current_limit(peak),
        .zero_current(zero_cur));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Sample currents change every cycle so both coefficient sets occur.
    always @(negedge ref_clk) begin
        rnd = xs(rnd);
        cur_sample <= 10'(rnd % 300);
    end

    // The event must trail each finished conversion by exactly one edge.
    always @(posedge ref_clk) begin
        if (resetn) begin
            check(cev, prev_done);
            if (cev === 1'b1)
                check(coef_high, exp_q.size() ? exp_q.pop_front() : 1'bx);
            if (adc_cur_done === 1'b1)
                exp_q.push_back(cur_sample >= 10'd150);
        end
        prev_done <= adc_cur_done & resetn;
    end

    task automatic sync_rise();
        int n;
        for (n = 0; n < 7000 && pwm_out !== 1'b0; n++) @(posedge ref_clk);
        for (n = 0; n < 7000 && pwm_out !== 1'b1; n++) @(posedge ref_clk);
    endtask

    task automatic count_hi(input int n, output int hi);
        hi = 0;
        repeat (n) begin
            @(posedge ref_clk);
            hi += (pwm_out === 1'b1);
        end
    endtask

    task automatic startup();
        int n;
        @(negedge ref_clk) start_req = 1'b1;
        for (n = 0; n < 40 && relay_close !== 1'b1; n++) begin
            check(pwm_out, 1'b0);
            @(posedge ref_clk);
        end
        check(relay_close, 1'b1);
        for (n = 0; n < 40 && soft_start !== 1'b1; n++) begin
            check(pwm_out, 1'b0);
            @(posedge ref_clk);
        end
        check(soft_start, 1'b1);
        @(negedge ref_clk) start_req = 1'b0;
    endtask

    task automatic run_duty(input pfcts_cnt_t d);
        int hi, tc, tv, k;
        logic last;
        pfcts_cnt_t cap;
        @(negedge ref_clk) duty = d;
        repeat (3) @(posedge ref_clk);
        sync_rise();
        hi = 0;
        tc = -1;
        tv = -1;
        cap = 12'hFFF;
        for (k = 0; k < 3076; k++) begin
            hi += (pwm_out === 1'b1);
            if (ctrig === 1'b1) tc = k;
            if (vtrig === 1'b1) tv = k;
            if (cond_valid === 1'b1) cap = cond_time;
            last = pwm_out;
            @(posedge ref_clk);
        end
        check(hi, d);
        check({last, pwm_out}, 2'b01);
        check(tc, (d / 2 == 0) ? -1 : d / 2);
        check(tv, d + (3076 - d) / 2);
        if (d < 3000)
            check(cap >= d + 8 && cap <= d + 15, 1'b1);
    endtask

    initial begin
        int n, h0, h1;
        logic [7:0] lv;
        fork
            begin
                repeat (90000) @(posedge ref_clk);
                failures++;
                end_of_test();
            end
        join_none
        repeat (6) @(negedge ref_clk);
        resetn = 1'b1;
        @(posedge ref_clk);
        check({relay_close, pwm_out}, 2'b00);
        startup();
        run_duty(12'h001);
        run_duty(12'hC03);
        repeat (2) run_duty(12'(rnd % 2990) + 12'h002);
        sync_rise();
        @(negedge ref_clk) over_cur = 1'b1;
        repeat (6) @(posedge ref_clk);
        count_hi(3076, n);
        check(n, 0);
        @(negedge ref_clk) over_cur = 1'b0;
        bulk = 10'h1CC;
        repeat (8) @(posedge ref_clk);
        count_hi(3076, n);
        check(n, 0);
        @(negedge ref_clk) bulk = 10'h190;
        sync_rise();
        check(pwm_out, 1'b1);
        @(negedge ref_clk) bulk = 10'h12C;
        repeat (8) @(posedge ref_clk);
        check({relay_close, pwm_out}, 2'b00);
        @(negedge ref_clk) bulk = 10'h190;
        count_hi(40, n);
        check(relay_close, 1'b0);
        startup();
        for (n = 0; n < 100 && slow_tick !== 1'b1; n++) @(posedge ref_clk);
        @(posedge ref_clk);
        for (n = 1; n < 100 && slow_tick !== 1'b1; n++) @(posedge ref_clk);
        check(n, 20);
        @(negedge ref_clk) lv = rnd[7:0];
        ref_levels = {8'h40, lv};
        repeat (300) @(posedge ref_clk);
        h0 = 0;
        h1 = 0;
        repeat (256) begin
            @(posedge ref_clk);
            h0 += (ref_pwm[0] === 1'b1);
            h1 += (ref_pwm[1] === 1'b1);
        end
        check(h0, lv);
        check(h1, 8'h40);
        end_of_test();
    end
endmodule
